// file: hw/doa_pkg.sv
// Package with the descriptor layout, register map and codes of the descriptor operand address unit.
package doa_pkg;

  // A 64-bit data descriptor as it sits in the descriptor register, most significant field first.
  typedef struct packed {
    logic [1:0] dtype;
    logic [2:0] size;
    logic read_only_flag;
    logic unscaled_flag;
    logic no_bound_check_flag;
    logic [23:0] bound;
    logic [31:0] origin;
  } doa_desc_s;

  // One store command; it stands while mem_req is high until mem_ack answers it.
  typedef struct packed {
    logic we;
    logic real_addr;
    logic bypass;
    logic [31:0] addr;
    logic [63:0] wdata;
  } doa_mem_cmd_s;

  // Register byte offsets.
  localparam logic [7:0] OFF_DESC_HI = 8'h00;
  localparam logic [7:0] OFF_DESC_LO = 8'h04;
  localparam logic [7:0] OFF_MODIFIER = 8'h08;
  localparam logic [7:0] OFF_DSR = 8'h0C;
  localparam logic [7:0] OFF_COMMAND = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_HW_HI = 8'h18;
  localparam logic [7:0] OFF_HW_LO = 8'h1C;
  localparam logic [7:0] OFF_ADDR = 8'h20;

  // Field positions of the descriptor status register, command and status.
  localparam int DSR_BCD = 0;
  localparam int DSR_BCD_ALT = 1;
  localparam int DSR_EXEC = 2;
  localparam int DSR_STORE = 3;
  localparam int DSR_MODP = 4;
  localparam int DSR_W = 5;
  localparam int CMD_START = 0;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_FAULT = 2;
  localparam int ST_CAUSE_LSB = 8;

  // Reset values.
  localparam logic [DSR_W-1:0] DSR_RESET = 5'h00;
  localparam logic [63:0] DESC_RESET = 64'h0;

  // Descriptor types, misc subtypes and element size codes.
  localparam logic [1:0] T_VEC = 2'h0;
  localparam logic [1:0] T_STR = 2'h1;
  localparam logic [1:0] T_DVEC = 2'h2;
  localparam logic [1:0] T_MISC = 2'h3;
  localparam logic [5:0] SUB_REAL = 6'h00;
  localparam logic [5:0] SUB_DIRECT = 6'h01;
  localparam logic [5:0] SUB_MARK = 6'h02;
  localparam logic [5:0] SUB_INDIRECT = 6'h03;
  localparam logic [2:0] SZ_1 = 3'h0;
  localparam logic [2:0] SZ_4 = 3'h2;
  localparam logic [2:0] SZ_8 = 3'h3;
  localparam logic [2:0] SZ_16 = 3'h4;
  localparam logic [2:0] SZ_32 = 3'h5;
  localparam logic [2:0] SZ_64 = 3'h6;
  localparam logic [6:0] HW_BITS = 7'h40;
  localparam logic [23:0] STR_MAX_BYTES = 24'h000008;

  // Fault cause codes shown in the status register.
  localparam logic [3:0] CAUSE_NONE = 4'h0;
  localparam logic [3:0] CAUSE_READ_ONLY = 4'h1;
  localparam logic [3:0] CAUSE_SIZE = 4'h2;
  localparam logic [3:0] CAUSE_BOUND = 4'h3;
  localparam logic [3:0] CAUSE_STR_SIZE = 4'h4;
  localparam logic [3:0] CAUSE_PRIV = 4'h5;
  localparam logic [3:0] CAUSE_TRUNC = 4'h6;
  localparam logic [3:0] CAUSE_UNSUPPORTED = 4'h7;

endpackage

// file: hw/doa_top.sv
// Descriptor operand address unit with its AHB-Lite register slave and store port.
//
// Overview of operation
// - Descriptor splits into type, size, three flags, 24-bit bound and 32-bit origin.
// - Size codes 000,010,011,100,101,110 mean 1,4,8,16,32,64-bit elements.
// - A read-only vector or type 2 descriptor used for a store faults instead of writing.
// - Scaled modifier shifts right 3 or 1, none, or left 1, 2, 3.
// - Unscaled flag set adds the modifier to the origin without shifting.
// - No-bound-check flag set skips the bound comparison.
// - With both check bits clear, modifier must be in zero to bound minus one, else fault.
// - Origin is a byte address; 16-bit elements ignore address bit zero.
// - 32 and 64-bit elements ignore the two lowest address bits.
// - Fetched short elements sit at the low end of the highway, rest zero.
// - Vector store writes the element, or faults without writing if discarded upper bits are nonzero.
// - String descriptors need size 011, otherwise they fault.
// - Strings add the modifier unscaled, length counts bytes, no bound check.
// - String operands use at most 64 bits, zero filled or zero checked.
// - Type 2 descriptors behave exactly like vector descriptors.
// - Real-address type uses 64-bit scaling, 8-byte aligned word, alternate check bit.
// - Real-address type is only accepted in executive mode.
// - Direct type accesses a 64-bit word bypassing operand buffers.
// - Read-and-mark fetch clears the store word after reading it.
// - The modifier is a signed 32-bit two's complement value.
// - Indirect descriptors reload and reinterpret; modifier applies only at the end.
`timescale 1ns/10ps
module doa_top #(
  parameter int HADDR_W = 32
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [HADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic mem_req,
  output doa_pkg::doa_mem_cmd_s mem_cmd,
  input wire logic mem_ack,
  input wire logic [63:0] mem_rdata,
  output logic access_fault,
  output logic access_done
);

  // The decoder compares whole addresses, so at least the map's span must be decodable.
  if (HADDR_W < 6 || HADDR_W > 32) begin : g_bad_addr_w
    $error("doa_top: HADDR_W must lie between 6 and 32");
  end

  typedef enum logic [3:0] {
    ST_IDLE, ST_DEC, ST_IND, ST_RD0, ST_RD1, ST_MOD, ST_WR0, ST_WR1, ST_MARK
  } doa_state_e;

  doa_state_e state_q;
  doa_pkg::doa_desc_s desc_q;
  logic [31:0] mod_q;
  logic [doa_pkg::DSR_W-1:0] dsr_q;
  logic [63:0] hw_q;
  logic [31:0] ea_q;
  logic [6:0] off_q;
  logic [6:0] width_q;
  logic need2_q;
  logic mark_q;
  logic [63:0] buf0_q;
  logic [63:0] buf1_q;
  logic done_q;
  logic fault_q;
  logic [3:0] cause_q;
  logic [31:0] hrdata_q;
  logic wen_q;
  logic [HADDR_W-1:0] wa_q;
  logic mem_req_q;
  doa_pkg::doa_mem_cmd_s mem_cmd_q;

  // Bus decode; only word transfers are expected, other sizes still act on the whole word.
  logic addr_ph;
  logic wr_en;
  logic start_w;
  logic store_op;
  logic modp;
  assign addr_ph = ce && hsel && hready && htrans[1];
  assign wr_en = ce && wen_q && hready;
  assign start_w = wr_en && (wa_q == HADDR_W'(doa_pkg::OFF_COMMAND)) && hwdata[doa_pkg::CMD_START];
  assign store_op = dsr_q[doa_pkg::DSR_STORE];
  assign modp = dsr_q[doa_pkg::DSR_MODP];

  // Descriptor decode, checks and element address, all settled before any store traffic.
  logic [3:0] cause_c;
  logic [6:0] width_c;
  logic [31:0] sh_c;
  logic [2:0] sub_c;
  logic [31:0] align_c;
  logic chk_c;
  logic real_c;
  logic byp_c;
  logic mark_c;
  logic ind_c;
  logic [31:0] ea_c;
  logic [6:0] off_c;
  logic need2_c;
  logic [5:0] subtype;
  assign subtype = {desc_q.size, desc_q.read_only_flag, desc_q.unscaled_flag, desc_q.no_bound_check_flag};

  always_comb begin
    cause_c = doa_pkg::CAUSE_NONE;
    width_c = 7'h00;
    sh_c = mod_q;
    sub_c = 3'h0;
    align_c = 32'hFFFFFFFF;
    chk_c = 1'b0;
    real_c = 1'b0;
    byp_c = 1'b0;
    mark_c = 1'b0;
    ind_c = 1'b0;
    unique case (desc_q.dtype)
      doa_pkg::T_VEC, doa_pkg::T_DVEC: begin
        chk_c = !dsr_q[doa_pkg::DSR_BCD] && !desc_q.no_bound_check_flag && modp;
        unique case (desc_q.size)
          doa_pkg::SZ_1: begin
            width_c = 7'h01;
            sh_c = desc_q.unscaled_flag ? mod_q : 32'($signed(mod_q) >>> 3);
            sub_c = desc_q.unscaled_flag ? 3'h0 : mod_q[2:0];
          end
          doa_pkg::SZ_4: begin
            width_c = 7'h04;
            sh_c = desc_q.unscaled_flag ? mod_q : 32'($signed(mod_q) >>> 1);
            sub_c = desc_q.unscaled_flag ? 3'h0 : {mod_q[0], 2'h0};
          end
          doa_pkg::SZ_8: begin
            width_c = 7'h08;
          end
          doa_pkg::SZ_16: begin
            width_c = 7'h10;
            sh_c = desc_q.unscaled_flag ? mod_q : {mod_q[30:0], 1'b0};
            align_c = 32'hFFFFFFFE;
          end
          doa_pkg::SZ_32: begin
            width_c = 7'h20;
            sh_c = desc_q.unscaled_flag ? mod_q : {mod_q[29:0], 2'h0};
            align_c = 32'hFFFFFFFC;
          end
          doa_pkg::SZ_64: begin
            width_c = doa_pkg::HW_BITS;
            sh_c = desc_q.unscaled_flag ? mod_q : {mod_q[28:0], 3'h0};
            align_c = 32'hFFFFFFFC;
          end
          default: cause_c = doa_pkg::CAUSE_SIZE;
        endcase
        if (cause_c == doa_pkg::CAUSE_NONE && desc_q.read_only_flag && store_op) begin
          cause_c = doa_pkg::CAUSE_READ_ONLY;
        end
      end
      doa_pkg::T_STR: begin
        // Strings are bytes: modifier unscaled, no bound check, width capped at the highway.
        if (desc_q.size != doa_pkg::SZ_8) begin
          cause_c = doa_pkg::CAUSE_STR_SIZE;
        end
        width_c = (desc_q.bound >= doa_pkg::STR_MAX_BYTES) ? doa_pkg::HW_BITS
                                                           : {1'b0, desc_q.bound[2:0], 3'h0};
      end
      default: begin
        width_c = doa_pkg::HW_BITS;
        sh_c = {mod_q[28:0], 3'h0};
        align_c = 32'hFFFFFFF8;
        chk_c = !dsr_q[doa_pkg::DSR_BCD_ALT] && modp;
        unique case (subtype)
          doa_pkg::SUB_REAL: begin
            real_c = 1'b1;
            if (!dsr_q[doa_pkg::DSR_EXEC]) begin
              cause_c = doa_pkg::CAUSE_PRIV;
            end
          end
          doa_pkg::SUB_DIRECT: byp_c = 1'b1;
          doa_pkg::SUB_MARK: begin
            byp_c = 1'b1;
            mark_c = !store_op;
          end
          doa_pkg::SUB_INDIRECT: begin
            ind_c = 1'b1;
            chk_c = 1'b0;
          end
          default: cause_c = doa_pkg::CAUSE_UNSUPPORTED;
        endcase
      end
    endcase
    // A negative modifier reads as huge when compared unsigned, so one compare covers both ends.
    if (cause_c == doa_pkg::CAUSE_NONE && chk_c && (mod_q >= {8'h00, desc_q.bound})) begin
      cause_c = doa_pkg::CAUSE_BOUND;
    end
    if (cause_c == doa_pkg::CAUSE_NONE && store_op && !ind_c && width_c < doa_pkg::HW_BITS &&
        (hw_q >> width_c) != 64'h0) begin
      cause_c = doa_pkg::CAUSE_TRUNC;
    end
    if (!modp) begin
      sh_c = 32'h0;
      sub_c = 3'h0;
    end
    if (ind_c) begin
      sh_c = 32'h0;
    end
    ea_c = (desc_q.origin + sh_c) & align_c;
    off_c = {1'b0, ea_c[2:0], 3'h0} + {4'h0, sub_c};
    need2_c = ({1'b0, off_c} + {1'b0, width_c}) > {1'b0, doa_pkg::HW_BITS};
  end

  // Element extraction and merge over a two-word window, so strings may straddle words.
  logic [127:0] pair;
  logic [7:0] lsh;
  logic [127:0] ext;
  logic [127:0] mask;
  logic [127:0] ins;
  logic [127:0] merged;
  assign pair = {buf0_q, buf1_q};
  assign lsh = 8'h80 - {1'b0, width_q};
  assign ext = (pair << off_q) >> lsh;
  assign mask = ({128{1'b1}} << lsh) >> off_q;
  assign ins = ({64'h0, hw_q} << lsh) >> off_q;
  assign merged = (pair & ~mask) | (ins & mask);

  // Completion of an operation and fetch results reaching the highway register.
  logic dec_stop;
  logic fin_w;
  logic hw_load;
  logic [63:0] hw_val;
  assign dec_stop = (state_q == ST_DEC) && !ind_c && (cause_c != doa_pkg::CAUSE_NONE || width_c == 7'h00);
  assign fin_w = dec_stop || (state_q == ST_MOD && !store_op && !mark_q) ||
                 (mem_ack && (state_q == ST_WR1 || state_q == ST_MARK || (state_q == ST_WR0 && !need2_q)));
  assign hw_load = (state_q == ST_MOD && !store_op) ||
                   (dec_stop && cause_c == doa_pkg::CAUSE_NONE && !store_op);
  assign hw_val = (state_q == ST_MOD) ? ext[63:0] : 64'h0;

  // AHB-Lite slave: zero wait states, read data registered at the address-phase edge.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0;
      wen_q <= 1'b0;
      wa_q <= '0;
    end else if (ce) begin
      if (hready) begin
        wen_q <= addr_ph && hwrite;
        wa_q <= haddr;
      end
      if (addr_ph && !hwrite) begin
        unique case (haddr)
          HADDR_W'(doa_pkg::OFF_DESC_HI): hrdata_q <= desc_q[63:32];
          HADDR_W'(doa_pkg::OFF_DESC_LO): hrdata_q <= desc_q[31:0];
          HADDR_W'(doa_pkg::OFF_MODIFIER): hrdata_q <= mod_q;
          HADDR_W'(doa_pkg::OFF_DSR): hrdata_q <= {27'h0, dsr_q};
          HADDR_W'(doa_pkg::OFF_STATUS): hrdata_q <= {20'h0, cause_q, 5'h0, fault_q, done_q, state_q != ST_IDLE};
          HADDR_W'(doa_pkg::OFF_HW_HI): hrdata_q <= hw_q[63:32];
          HADDR_W'(doa_pkg::OFF_HW_LO): hrdata_q <= hw_q[31:0];
          HADDR_W'(doa_pkg::OFF_ADDR): hrdata_q <= ea_q;
          default: hrdata_q <= 32'h0;
        endcase
      end
    end
  end

  // Software registers; the descriptor also reloads through indirection, the highway on fetch.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      desc_q <= doa_pkg::DESC_RESET;
      mod_q <= 32'h0;
      dsr_q <= doa_pkg::DSR_RESET;
      hw_q <= 64'h0;
    end else if (ce) begin
      if (state_q == ST_IND && mem_ack) begin
        desc_q <= mem_rdata;
      end else if (wr_en && wa_q == HADDR_W'(doa_pkg::OFF_DESC_HI) && state_q == ST_IDLE) begin
        desc_q[63:32] <= hwdata;
      end else if (wr_en && wa_q == HADDR_W'(doa_pkg::OFF_DESC_LO) && state_q == ST_IDLE) begin
        desc_q[31:0] <= hwdata;
      end
      if (wr_en && wa_q == HADDR_W'(doa_pkg::OFF_MODIFIER) && state_q == ST_IDLE) begin
        mod_q <= hwdata;
      end
      if (wr_en && wa_q == HADDR_W'(doa_pkg::OFF_DSR) && state_q == ST_IDLE) begin
        dsr_q <= hwdata[doa_pkg::DSR_W-1:0];
      end
      if (hw_load) begin
        hw_q <= hw_val;
      end else if (wr_en && wa_q == HADDR_W'(doa_pkg::OFF_HW_HI) && state_q == ST_IDLE) begin
        hw_q[63:32] <= hwdata;
      end else if (wr_en && wa_q == HADDR_W'(doa_pkg::OFF_HW_LO) && state_q == ST_IDLE) begin
        hw_q[31:0] <= hwdata;
      end
    end
  end

  // Sticky done and fault flags; a hardware set wins over a write-one-to-clear.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_q <= 1'b0;
      fault_q <= 1'b0;
      cause_q <= doa_pkg::CAUSE_NONE;
    end else if (ce) begin
      if (fin_w) begin
        done_q <= 1'b1;
      end else if (start_w && state_q == ST_IDLE) begin
        done_q <= 1'b0;
      end else if (wr_en && wa_q == HADDR_W'(doa_pkg::OFF_STATUS) && hwdata[doa_pkg::ST_DONE]) begin
        done_q <= 1'b0;
      end
      if (dec_stop && cause_c != doa_pkg::CAUSE_NONE) begin
        fault_q <= 1'b1;
        cause_q <= cause_c;
      end else if ((start_w && state_q == ST_IDLE) ||
                   (wr_en && wa_q == HADDR_W'(doa_pkg::OFF_STATUS) && hwdata[doa_pkg::ST_FAULT])) begin
        fault_q <= 1'b0;
        cause_q <= doa_pkg::CAUSE_NONE;
      end
    end
  end

  // Sequencer and store port; back-to-back commands keep mem_req high with a new command.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ST_IDLE;
      mem_req_q <= 1'b0;
      mem_cmd_q <= '0;
      buf0_q <= 64'h0;
      buf1_q <= 64'h0;
      ea_q <= 32'h0;
      off_q <= 7'h00;
      width_q <= 7'h00;
      need2_q <= 1'b0;
      mark_q <= 1'b0;
    end else if (ce) begin
      unique case (state_q)
        ST_IDLE: begin
          if (start_w) begin
            state_q <= ST_DEC;
          end
        end
        ST_DEC: begin
          ea_q <= ea_c;
          off_q <= off_c;
          width_q <= width_c;
          need2_q <= need2_c;
          mark_q <= mark_c;
          mem_cmd_q.real_addr <= real_c;
          mem_cmd_q.bypass <= byp_c;
          mem_cmd_q.we <= 1'b0;
          mem_cmd_q.wdata <= 64'h0;
          if (ind_c) begin
            mem_req_q <= 1'b1;
            mem_cmd_q.addr <= {ea_c[31:3], 3'h0};
            state_q <= ST_IND;
          end else if (dec_stop) begin
            state_q <= ST_IDLE;
          end else begin
            mem_req_q <= 1'b1;
            mem_cmd_q.addr <= {ea_c[31:3], 3'h0};
            state_q <= ST_RD0;
          end
        end
        ST_IND: begin
          if (mem_ack) begin
            mem_req_q <= 1'b0;
            state_q <= ST_DEC;
          end
        end
        ST_RD0: begin
          if (mem_ack) begin
            buf0_q <= mem_rdata;
            mem_req_q <= need2_q;
            mem_cmd_q.addr <= mem_cmd_q.addr + 32'h8;
            state_q <= need2_q ? ST_RD1 : ST_MOD;
          end
        end
        ST_RD1: begin
          if (mem_ack) begin
            buf1_q <= mem_rdata;
            mem_req_q <= 1'b0;
            state_q <= ST_MOD;
          end
        end
        ST_MOD: begin
          mem_cmd_q.addr <= {ea_q[31:3], 3'h0};
          if (store_op) begin
            mem_req_q <= 1'b1;
            mem_cmd_q.we <= 1'b1;
            mem_cmd_q.wdata <= merged[127:64];
            state_q <= ST_WR0;
          end else if (mark_q) begin
            mem_req_q <= 1'b1;
            mem_cmd_q.we <= 1'b1;
            mem_cmd_q.wdata <= 64'h0;
            state_q <= ST_MARK;
          end else begin
            state_q <= ST_IDLE;
          end
        end
        ST_WR0: begin
          if (mem_ack) begin
            mem_req_q <= need2_q;
            mem_cmd_q.addr <= mem_cmd_q.addr + 32'h8;
            mem_cmd_q.wdata <= merged[63:0];
            state_q <= need2_q ? ST_WR1 : ST_IDLE;
          end
        end
        ST_WR1, ST_MARK: begin
          if (mem_ack) begin
            mem_req_q <= 1'b0;
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign mem_req = mem_req_q;
  assign mem_cmd = mem_cmd_q;
  assign access_fault = fault_q;
  assign access_done = done_q;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_RO_FAULT: assert property (ce && state_q == ST_DEC && desc_q.dtype == doa_pkg::T_VEC &&
    desc_q.size == doa_pkg::SZ_8 && desc_q.read_only_flag && store_op |=> fault_q && cause_q == doa_pkg::CAUSE_READ_ONLY)
    else $error("read-only store did not fault");
  AST_NO_STORE_ON_FAULT: assert property (ce && dec_stop |=> state_q == ST_IDLE && !mem_req_q)
    else $error("store traffic after a failed check");
  AST_BAD_SIZE: assert property (ce && state_q == ST_DEC && desc_q.dtype == doa_pkg::T_DVEC &&
    (desc_q.size == 3'h1 || desc_q.size == 3'h7) |=> fault_q && cause_q == doa_pkg::CAUSE_SIZE)
    else $error("undefined size code accepted");
  AST_STR_SIZE: assert property (ce && state_q == ST_DEC && desc_q.dtype == doa_pkg::T_STR &&
    desc_q.size != doa_pkg::SZ_8 |=> fault_q && cause_q == doa_pkg::CAUSE_STR_SIZE)
    else $error("string with wrong size accepted");
  AST_PRIV: assert property (ce && state_q == ST_DEC && desc_q.dtype == doa_pkg::T_MISC &&
    subtype == doa_pkg::SUB_REAL && !dsr_q[doa_pkg::DSR_EXEC] |=> cause_q == doa_pkg::CAUSE_PRIV)
    else $error("real-address descriptor accepted outside executive mode");
  AST_BOUND_NEG: assert property (ce && state_q == ST_DEC && desc_q.dtype == doa_pkg::T_VEC &&
    desc_q.size == doa_pkg::SZ_8 && modp && mod_q[31] && !dsr_q[doa_pkg::DSR_BCD] &&
    !desc_q.no_bound_check_flag |=> fault_q && cause_q == doa_pkg::CAUSE_BOUND)
    else $error("negative modifier passed the bound check");
  AST_WORD_ALIGN: assert property (ce && state_q == ST_DEC && desc_q.dtype == doa_pkg::T_VEC &&
    desc_q.size == doa_pkg::SZ_32 |=> ea_q[1:0] == 2'h0)
    else $error("32-bit element not word aligned");
  AST_ZERO_FILL: assert property (ce && $rose(done_q) && !store_op && !fault_q &&
    width_q < doa_pkg::HW_BITS |-> (hw_q >> width_q) == 64'h0)
    else $error("fetched element not zero filled");
  AST_MARK_ZERO: assert property (state_q == ST_MARK && mem_req_q |-> mem_cmd_q.we &&
    mem_cmd_q.wdata == 64'h0 && mem_cmd_q.bypass)
    else $error("read-and-mark did not clear the word");
  AST_CMD_STABLE: assert property (mem_req_q && !mem_ack |=> mem_req_q && $stable(mem_cmd_q))
    else $error("store command changed while waiting");

endmodule

// file: tb/doa_store_model.sv
// Behavioural store that answers the unit's store port, promptly or after a set lag.
`timescale 1ns/10ps
module doa_store_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic mem_req,
  input wire doa_pkg::doa_mem_cmd_s mem_cmd,
  output logic mem_ack,
  output logic [63:0] mem_rdata
);
  logic [63:0] mem [8];
  int lag = 0;
  int cnt;
  // Between answers the data lines toggle, so a stale word is never mistaken for a fresh one.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_ack <= 1'h0;
      mem_rdata <= 64'h5A5A5A5A5A5A5A5A;
      cnt <= 0;
    end else if (mem_req && !mem_ack && cnt >= lag) begin
      mem_ack <= 1'h1;
      mem_rdata <= mem[mem_cmd.addr[5:3]];
      if (mem_cmd.we) mem[mem_cmd.addr[5:3]] <= mem_cmd.wdata;
      cnt <= 0;
    end else begin
      mem_ack <= 1'h0;
      mem_rdata <= ~mem_rdata;
      cnt <= cnt + (mem_req ? 1 : 0);
    end
  end
endmodule

// file: tb/doa_top_bench.sv
// Self-checking bench for the descriptor operand address unit and its store.
`timescale 1ns/10ps
module doa_top_bench;
  logic hclk = 1'h0;
  logic hresetn = 1'h0;
  logic hsel = 1'h0;
  logic hwrite = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, st, ea;
  logic hreadyout, hresp, mem_req, mem_ack, access_fault, access_done;
  logic [63:0] mem_rdata, hwv;
  doa_pkg::doa_mem_cmd_s mem_cmd;
  int n_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  doa_top i_doa_top (.hclk(hclk), .hresetn(hresetn), .ce(1'h1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .mem_req(mem_req), .mem_cmd(mem_cmd), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .access_fault(access_fault), .access_done(access_done));
  doa_store_model i_doa_store_model (.hclk(hclk), .hresetn(hresetn), .mem_req(mem_req), .mem_cmd(mem_cmd),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  // Clock of 50 ns and a cycle ceiling that cuts a hang short.
  always #25 hclk = ~hclk;
  always @(posedge hclk) begin
    cyc++;
    if (cyc > 30000) begin
      n_errors++;
      print_verdict();
    end
  end
  // Initial store contents, chosen so every byte lane is told apart.
  function automatic logic [63:0] w(input int i);
    return 64'h0123456789ABCDEF + 64'(i) * 64'h1111;
  endfunction
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    num_checks++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // One single AHB-Lite word transfer; the master holds each phase until hready is seen high.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    @(posedge hclk);
    while (hreadyout !== 1'h1) @(posedge hclk);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'h1) @(posedge hclk);
    q = hrdata;
  endtask
  // Loads a descriptor, starts it and collects status, highway and element address.
  task automatic run(input logic [63:0] d, input logic [31:0] m, input logic [4:0] r, input logic [63:0] h);
    logic [31:0] q;
    int n;
    bus(1'h1, doa_pkg::OFF_STATUS, 32'h6, q);
    bus(1'h1, doa_pkg::OFF_DESC_HI, d[63:32], q);
    bus(1'h1, doa_pkg::OFF_DESC_LO, d[31:0], q);
    bus(1'h1, doa_pkg::OFF_MODIFIER, m, q);
    bus(1'h1, doa_pkg::OFF_DSR, {27'h0, r}, q);
    bus(1'h1, doa_pkg::OFF_HW_HI, h[63:32], q);
    bus(1'h1, doa_pkg::OFF_HW_LO, h[31:0], q);
    bus(1'h1, doa_pkg::OFF_COMMAND, 32'h1, q);
    n = 0;
    while (access_done !== 1'h1 && n < 300) begin
      @(posedge hclk);
      n++;
    end
    chk(access_done, 1'h1);
    chk(hresp, 1'h0);
    bus(1'h0, doa_pkg::OFF_STATUS, 32'h0, st);
    bus(1'h0, doa_pkg::OFF_HW_HI, 32'h0, hwv[63:32]);
    bus(1'h0, doa_pkg::OFF_HW_LO, 32'h0, hwv[31:0]);
    bus(1'h0, doa_pkg::OFF_ADDR, 32'h0, ea);
  endtask
  // Fetch through a descriptor with origin 16 and bound 16; wd of zero skips the value compare.
  task automatic fe(input logic [1:0] t, input logic [2:0] sz, fl, input logic [31:0] m, x, input logic [4:0] r,
    input int wd);
    logic [63:0] v;
    run({t, sz, fl, 24'h10, 32'h10}, m, r, 64'h0);
    v = w(x[5:3]) << (8 * x[2:0]);
    chk(ea, x);
    chk(access_fault, 1'h0);
    if (wd > 0) chk(hwv, v >> (64 - wd));
  endtask
  task automatic t_vec;
    fe(2'h0, doa_pkg::SZ_1, 3'h0, 32'hB, 32'h11, 5'h10, 0);
    fe(2'h0, doa_pkg::SZ_4, 3'h0, 32'h5, 32'h12, 5'h10, 0);
    fe(2'h0, doa_pkg::SZ_8, 3'h0, 32'h5, 32'h15, 5'h10, 8);
    fe(2'h0, doa_pkg::SZ_16, 3'h0, 32'h3, 32'h16, 5'h10, 16);
    fe(2'h0, doa_pkg::SZ_32, 3'h0, 32'h1, 32'h14, 5'h10, 32);
    fe(2'h0, doa_pkg::SZ_64, 3'h0, 32'h1, 32'h18, 5'h10, 64);
    fe(2'h2, doa_pkg::SZ_16, 3'h2, 32'h3, 32'h12, 5'h10, 16);
    fe(2'h0, doa_pkg::SZ_32, 3'h2, 32'h6, 32'h14, 5'h10, 32);
    fe(2'h0, doa_pkg::SZ_8, 3'h1, 32'hFFFFFFFF, 32'h0F, 5'h10, 8);
    fe(2'h0, doa_pkg::SZ_8, 3'h0, 32'h10, 32'h20, 5'h11, 8);
    fe(2'h3, 3'h0, 3'h0, 32'h1, 32'h18, 5'h14, 64);
    fe(2'h3, 3'h0, 3'h1, 32'h1, 32'h18, 5'h10, 64);
    fe(2'h3, 3'h0, 3'h0, 32'h10, 32'h90, 5'h16, 64);
  endtask
  // A refused access must report its cause and leave the store word untouched.
  task automatic ft(input logic [63:0] d, input logic [31:0] m, input logic [4:0] r, input logic [63:0] h,
    input logic [3:0] c);
    run(d, m, r, h);
    chk(st[11:8], c);
    chk(access_fault, 1'h1);
    chk(i_doa_store_model.mem[2], w(2));
  endtask
  task automatic t_flt;
    ft({5'h3, 3'h4, 24'h10, 32'h10}, 32'h1, 5'h18, 64'h1, 4'h1);
    ft({5'h1, 3'h0, 24'h10, 32'h10}, 32'h1, 5'h10, 64'h0, 4'h2);
    ft({5'h17, 3'h0, 24'h10, 32'h10}, 32'h1, 5'h18, 64'h0, 4'h2);
    ft({5'h3, 3'h0, 24'h10, 32'h10}, 32'h10, 5'h10, 64'h0, 4'h3);
    ft({5'h3, 3'h0, 24'h10, 32'h10}, 32'hFFFFFFFF, 5'h18, 64'h0, 4'h3);
    ft({5'hA, 3'h0, 24'h4, 32'h10}, 32'h0, 5'h10, 64'h0, 4'h4);
    ft({5'h18, 3'h0, 24'h10, 32'h10}, 32'h0, 5'h10, 64'h0, 4'h5);
    ft({5'h3, 3'h0, 24'h10, 32'h10}, 32'h1, 5'h18, 64'h100, 4'h6);
    ft({5'h18, 3'h4, 24'h10, 32'h10}, 32'h0, 5'h14, 64'h0, 4'h7);
  endtask
  // A slow store takes a 16-bit write; strings, mark and indirect follow.
  task automatic t_misc;
    logic [63:0] v;
    i_doa_store_model.lag = 3;
    run({5'h4, 3'h0, 24'h10, 32'h10}, 32'h1, 5'h18, 64'hBEEF);
    v = w(2);
    chk(i_doa_store_model.mem[2], {v[63:48], 16'hBEEF, v[31:0]});
    i_doa_store_model.lag = 0;
    run({5'hB, 3'h0, 24'h3, 32'h10}, 32'h6, 5'h10, 64'h0);
    chk(hwv, {40'h0, v[15:0], 8'h01});
    run({5'hB, 3'h0, 24'hC, 32'h18}, 32'h0, 5'h10, 64'h0);
    chk(hwv, w(3));
    run({5'h18, 3'h2, 24'h10, 32'h30}, 32'h0, 5'h10, 64'h0);
    chk(hwv, w(6));
    chk(i_doa_store_model.mem[6], 64'h0);
    run({5'h18, 3'h3, 24'h0, 32'h38}, 32'h5, 5'h10, 64'h0);
    chk(ea, 32'h15);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Store preload, reset for six cycles, then the scenarios.
  initial begin
    for (int i = 0; i < 8; i++) i_doa_store_model.mem[i] = w(i);
    i_doa_store_model.mem[7] = {5'h3, 3'h0, 24'h10, 32'h10};
    repeat (6) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    t_vec();
    t_flt();
    t_misc();
    print_verdict();
  end
endmodule
